//--- common/fepc_pkg.sv
// fepc_pkg: constants and types for the flash clear and page write sequencer
`default_nettype none
package fepc_pkg;
	// core clock rate, 40 ns period
	localparam int CLK_MHZ = 25;

	// command opcodes as they arrive on the serial input
	localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
	localparam logic [7:0] OP_SECTOR_CLEAR = 8'h20;
	localparam logic [7:0] OP_BLOCK32_CLEAR = 8'h52;
	localparam logic [7:0] OP_BLOCK64_CLEAR = 8'hd8;
	localparam logic [7:0] OP_ARRAY_CLEAR_A = 8'h60;
	localparam logic [7:0] OP_ARRAY_CLEAR_B = 8'hc7;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;

	// frame byte positions: opcode, three address bytes, then data
	localparam logic [2:0] BYTE_OPCODE = 3'h0;
	localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
	localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
	localparam logic [2:0] BYTE_ADDR_LO = 3'h3;
	localparam logic [2:0] BYTE_DATA_FIRST = 3'h4;
	localparam logic [2:0] BYTE_DATA_MORE = 3'h5;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// region sizes given by the lowest address bit that selects them
	localparam int SECTOR_LSB = 12;
	localparam int BLOCK32_LSB = 15;
	localparam int BLOCK64_LSB = 16;
	localparam int PAGE_LSB = 8;
	localparam int PAGE_BYTES = 256;

	// array size and protection granule (64K units)
	localparam logic [24:0] ARRAY_BYTES = 25'h0200000;
	localparam logic [24:0] PROT_UNIT_BYTES = 25'h0010000;

	// values after reset
	localparam logic RESET_LATCH = 1'b0;
	localparam logic [2:0] RESET_BIT_CNT = 3'h0;

	// self-timed cycle lengths in microseconds, and in core cycles
	localparam int SECTOR_CLEAR_TIME_US = 300;
	localparam int BLOCK32_CLEAR_TIME_US = 800;
	localparam int BLOCK64_CLEAR_TIME_US = 1200;
	localparam int ARRAY_CLEAR_TIME_US = 20000;
	localparam int PAGE_WRITE_TIME_US = 500;
	localparam int SECTOR_CLEAR_CYCLES = SECTOR_CLEAR_TIME_US * CLK_MHZ;
	localparam int BLOCK32_CLEAR_CYCLES = BLOCK32_CLEAR_TIME_US * CLK_MHZ;
	localparam int BLOCK64_CLEAR_CYCLES = BLOCK64_CLEAR_TIME_US * CLK_MHZ;
	localparam int ARRAY_CLEAR_CYCLES = ARRAY_CLEAR_TIME_US * CLK_MHZ;
	localparam int PAGE_WRITE_CYCLES = PAGE_WRITE_TIME_US * CLK_MHZ;
	localparam int TIMER_W = 24;

	// kind of array operation handed to the array port
	typedef enum logic [2:0] {
		FEPC_SECTOR = 3'h0,
		FEPC_BLOCK32 = 3'h1,
		FEPC_BLOCK64 = 3'h2,
		FEPC_ARRAY = 3'h3,
		FEPC_PROGRAM = 3'h4
	} fepc_kind_t;

	// one word to the array: clears carry a base address, programs a byte
	typedef struct packed {
		fepc_kind_t kind;
		logic [23:0] addr;
		logic [7:0] data;
	} fepc_op_t;

	// execution sequencer states
	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_STREAM = 4'h2,
		ST_WAIT = 4'h4,
		ST_DONE = 4'h8
	} fepc_state_t;
endpackage
`default_nettype wire

//--- rtl/fepc_core.sv
// fepc_core: serial command decode, clear and page write sequencing
`timescale 1ns/1ps
`default_nettype none
// Operation
// [R01] sector clear 20 needs latch, clears sector
// [R02] sector chosen by address bits 12 upward
// [R03] clears need select rise after address byte
// [R04] host sends opcode, three address bytes
// [R05] sector cycle: busy held, then latch cleared
// [R06] protected sector is not cleared
// [R07] 32K clear 52 with latch, busy cycle
// [R08] protected 32K: array kept, latch cleared
// [R09] 64K clear D8 with latch, busy cycle
// [R10] protected 64K block is not cleared
// [R11] array clear 60 or C7, opcode only
// [R12] array clear only with no protection
// [R13] array cycle: busy held, then latch cleared
// [R14] page write: latch, address, data bytes
// [R15] only the last 256 bytes kept
// [R16] byte address wraps within the page
// [R17] short writes touch only sent bytes
// [R18] page write needs select rise on byte
// [R19] page cycle: busy held, then latch cleared
// [R20] protected page is not written
// [R21] host writes each cleared page once
// [R22] no latch: command ignored entirely
// [R23] 32K from bit 15, 64K from bit 16
module fepc_core import fepc_pkg::*; #(
	parameter int SECTOR_CLEAR_CYC = SECTOR_CLEAR_CYCLES,
	parameter int BLOCK32_CLEAR_CYC = BLOCK32_CLEAR_CYCLES,
	parameter int BLOCK64_CLEAR_CYC = BLOCK64_CLEAR_CYCLES,
	parameter int ARRAY_CLEAR_CYC = ARRAY_CLEAR_CYCLES,
	parameter int PAGE_WRITE_CYC = PAGE_WRITE_CYCLES
) (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// serial link pins from the host
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic si_in,
	// protection setting
	input wire logic [4:0] protect_level_bits_in,
	// status flags
	output logic write_latch_flag_out,
	output logic op_in_progress_flag_out,
	// array operation stream
	output fepc_op_t array_op_out,
	output logic array_op_valid_out,
	input wire logic array_op_ready_in
);

	// pin synchronisers: [0] first stage, [1] second, [2] edge history on select and clock only
	logic [2:0] cs_sync_q;
	logic [2:0] sclk_sync_q;
	logic [1:0] si_sync_q;
	// frame shifter state
	logic [2:0] bit_cnt_q;
	logic [2:0] byte_cnt_q;
	logic [6:0] shift_q;
	logic [7:0] opcode_q;
	logic [23:0] addr_q;
	logic [7:0] ptr_q;
	// page buffer and which offsets hold fresh data
	logic [7:0] page_mem [PAGE_BYTES];
	logic [PAGE_BYTES-1:0] mask_q;
	// flags and sequencer
	logic latch_q;
	fepc_state_t state_q;
	fepc_op_t op_q;
	logic [7:0] idx_q;
	logic [TIMER_W-1:0] timer_q;
	// two-entry output buffer
	fepc_op_t fifo_mem [2];
	logic wr_ptr_q;
	logic rd_ptr_q;
	logic [1:0] fifo_cnt_q;

	// derived strobes
	logic cs_low;
	logic cs_fall;
	logic cs_rise;
	logic sclk_rise;
	logic byte_done;
	logic [7:0] new_byte;
	logic idle;
	logic aligned;
	logic push_valid;
	logic fifo_ready;
	logic pop;
	logic advance;

	// decode results at select rise
	logic unlock_go;
	logic start_go;
	logic refuse_clear_latch;
	fepc_kind_t go_kind;
	logic [23:0] go_base;
	logic [TIMER_W-1:0] go_time;

	// true when any byte of [lo,hi] lies in the protected area
	function automatic logic covered(input logic [23:0] lo, input logic [23:0] hi, input logic [4:0] bp);
		logic [24:0] reg_bytes;
		logic [24:0] reg_lo;
		reg_bytes = PROT_UNIT_BYTES << (bp[2:0] - 3'h1);
		reg_lo = (reg_bytes >= ARRAY_BYTES) ? 25'h0 : (ARRAY_BYTES - reg_bytes);
		if (bp[2:0] == 3'h0) begin
			covered = 1'b0;
		end else if (bp[3]) begin
			covered = {1'b0, lo} < reg_bytes; // bottom-anchored area
		end else begin
			covered = {1'b0, hi} >= reg_lo; // top-anchored area
		end
	endfunction

	// low-order mask of a region selected from bit lsb upward
	function automatic logic [23:0] low_mask(input int lsb);
		low_mask = 24'((25'h1 << lsb) - 25'h1);
	endfunction

	assign cs_low = ~cs_sync_q[1];
	assign cs_fall = ~cs_sync_q[1] & cs_sync_q[2];
	assign cs_rise = cs_sync_q[1] & ~cs_sync_q[2];
	assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
	assign byte_done = cs_low & sclk_rise & (bit_cnt_q == BIT_LAST);
	assign new_byte = {shift_q, si_sync_q[1]};
	assign idle = (state_q == ST_IDLE);
	// a rise with no partial byte pending
	assign aligned = (bit_cnt_q == RESET_BIT_CNT);

	// synchronise pins; the core clock oversamples the serial clock
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			cs_sync_q <= 3'h7;
			sclk_sync_q <= 3'h0;
			si_sync_q <= 2'h0;
		end else if (clk_en_in) begin
			cs_sync_q <= {cs_sync_q[1:0], cs_n_in};
			sclk_sync_q <= {sclk_sync_q[1:0], sclk_in};
			si_sync_q <= {si_sync_q[0], si_in};
		end
	end

	// bit and byte counting within a frame, msb first on rising edges
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			bit_cnt_q <= RESET_BIT_CNT;
			byte_cnt_q <= BYTE_OPCODE;
			shift_q <= 7'h00;
		end else if (clk_en_in) begin
			if (cs_fall) begin
				bit_cnt_q <= RESET_BIT_CNT;
				byte_cnt_q <= BYTE_OPCODE;
			end else if (cs_low && sclk_rise) begin
				shift_q <= new_byte[6:0];
				bit_cnt_q <= bit_cnt_q + 3'h1;
				// saturate: anything past the first data byte looks alike
				if (bit_cnt_q == BIT_LAST && byte_cnt_q != BYTE_DATA_MORE) begin
					byte_cnt_q <= byte_cnt_q + 3'h1;
				end
			end
		end
	end

	// capture opcode and the three address bytes
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			opcode_q <= 8'h00;
			addr_q <= 24'h000000;
		end else if (clk_en_in && byte_done) begin
			unique case (byte_cnt_q)
				BYTE_OPCODE: opcode_q <= new_byte;
				BYTE_ADDR_HI: addr_q[23:16] <= new_byte; // [R04]
				BYTE_ADDR_MID: addr_q[15:8] <= new_byte;
				BYTE_ADDR_LO: addr_q[7:0] <= new_byte;
				default: ; // data bytes handled by the page buffer
			endcase
		end
	end

	// page buffer fill; frames during a busy cycle must not disturb it
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			ptr_q <= 8'h00;
			mask_q <= '0;
		end else if (clk_en_in && idle) begin
			if (cs_fall) begin
				mask_q <= '0;
			end else if (byte_done && byte_cnt_q == BYTE_ADDR_LO) begin
				ptr_q <= new_byte; // start offset within the page
			end else if (byte_done && byte_cnt_q >= BYTE_DATA_FIRST && opcode_q == OP_PAGE_WRITE) begin
				mask_q[ptr_q] <= 1'b1; // [R17]
				ptr_q <= ptr_q + 8'h01; // [R16]
			end
		end
	end

	// buffer storage; later bytes overwrite older ones at the same offset
	always_ff @(posedge clk_in) begin
		if (clk_en_in && idle && byte_done && byte_cnt_q >= BYTE_DATA_FIRST && opcode_q == OP_PAGE_WRITE) begin
			page_mem[ptr_q] <= new_byte; // [R15]
		end
	end

	// command decode at the rise of select
	always_comb begin
		unlock_go = 1'b0;
		start_go = 1'b0;
		refuse_clear_latch = 1'b0;
		go_kind = FEPC_SECTOR;
		go_base = addr_q;
		go_time = TIMER_W'(SECTOR_CLEAR_CYC);
		if (idle && cs_rise && aligned) begin
			unique case (opcode_q)
				OP_WRITE_UNLOCK: begin
					unlock_go = (byte_cnt_q == BYTE_ADDR_HI);
				end
				OP_SECTOR_CLEAR: begin
					go_base = addr_q & ~low_mask(SECTOR_LSB); // [R02]
					start_go = latch_q && byte_cnt_q == BYTE_DATA_FIRST // [R01] [R03] [R22]
						&& !covered(go_base, addr_q | low_mask(SECTOR_LSB), protect_level_bits_in); // [R06]
				end
				OP_BLOCK32_CLEAR: begin
					go_kind = FEPC_BLOCK32;
					go_base = addr_q & ~low_mask(BLOCK32_LSB); // [R23]
					go_time = TIMER_W'(BLOCK32_CLEAR_CYC);
					if (latch_q && byte_cnt_q == BYTE_DATA_FIRST) begin // [R07] [R03]
						if (covered(go_base, addr_q | low_mask(BLOCK32_LSB), protect_level_bits_in)) begin
							refuse_clear_latch = 1'b1; // [R08]
						end else begin
							start_go = 1'b1;
						end
					end
				end
				OP_BLOCK64_CLEAR: begin
					go_kind = FEPC_BLOCK64;
					go_base = addr_q & ~low_mask(BLOCK64_LSB); // [R23]
					go_time = TIMER_W'(BLOCK64_CLEAR_CYC);
					start_go = latch_q && byte_cnt_q == BYTE_DATA_FIRST // [R09] [R03]
						&& !covered(go_base, addr_q | low_mask(BLOCK64_LSB), protect_level_bits_in); // [R10]
				end
				OP_ARRAY_CLEAR_A, OP_ARRAY_CLEAR_B: begin
					go_kind = FEPC_ARRAY;
					go_base = 24'h000000;
					go_time = TIMER_W'(ARRAY_CLEAR_CYC);
					start_go = latch_q && byte_cnt_q == BYTE_ADDR_HI // [R11]
						&& protect_level_bits_in[2:0] == 3'h0; // [R12]
				end
				OP_PAGE_WRITE: begin
					go_kind = FEPC_PROGRAM;
					go_base = addr_q & ~low_mask(PAGE_LSB);
					go_time = TIMER_W'(PAGE_WRITE_CYC);
					start_go = latch_q && byte_cnt_q >= BYTE_DATA_MORE // [R14] [R18]
						&& !covered(go_base, addr_q | low_mask(PAGE_LSB), protect_level_bits_in); // [R20]
				end
				default: ; // unknown opcodes are left alone
			endcase
		end
	end

	// write latch: set by unlock, cleared when a cycle ends
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			latch_q <= RESET_LATCH;
		end else if (clk_en_in) begin
			if (unlock_go) begin
				latch_q <= 1'b1;
			end else if (state_q == ST_DONE || refuse_clear_latch) begin
				latch_q <= 1'b0; // [R05] [R13] [R19] [R08]
			end
		end
	end

	// stream handshake: clears push one word, page write one per fresh byte
	assign push_valid = (state_q == ST_STREAM) && (op_q.kind != FEPC_PROGRAM || mask_q[idx_q]);
	assign advance = !push_valid || fifo_ready;

	// execution sequencer; busy is every state but idle
	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			state_q <= ST_IDLE;
			op_q <= '0;
			idx_q <= 8'h00;
			timer_q <= '0;
		end else if (clk_en_in) begin
			unique case (state_q)
				ST_IDLE: begin
					if (start_go) begin
						state_q <= ST_STREAM; // [R05] [R13] [R19]
						op_q <= '{kind: go_kind, addr: go_base, data: 8'hff};
						idx_q <= 8'h00;
						timer_q <= go_time;
					end
				end
				ST_STREAM: begin
					// receiver stall holds the walk, never drops a byte
					if (advance) begin
						idx_q <= idx_q + 8'h01;
						if (op_q.kind != FEPC_PROGRAM || idx_q == 8'hff) begin
							state_q <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					if (timer_q <= TIMER_W'(1)) begin
						state_q <= ST_DONE;
					end else begin
						timer_q <= timer_q - TIMER_W'(1);
					end
				end
				ST_DONE: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// two-entry output buffer
	assign fifo_ready = (fifo_cnt_q != 2'h2);
	assign pop = array_op_valid_out && array_op_ready_in;

	always_ff @(posedge clk_in) begin
		if (!reset_n_in) begin
			wr_ptr_q <= 1'b0;
			rd_ptr_q <= 1'b0;
			fifo_cnt_q <= 2'h0;
		end else if (clk_en_in) begin
			if (push_valid && fifo_ready) begin
				wr_ptr_q <= ~wr_ptr_q;
			end
			if (pop) begin
				rd_ptr_q <= ~rd_ptr_q;
			end
			fifo_cnt_q <= fifo_cnt_q + {1'b0, push_valid && fifo_ready} - {1'b0, pop};
		end
	end

	// buffer words; page bytes carry their in-page offset in the address
	always_ff @(posedge clk_in) begin
		if (clk_en_in && push_valid && fifo_ready) begin
			fifo_mem[wr_ptr_q] <= '{kind: op_q.kind,
				addr: (op_q.kind == FEPC_PROGRAM) ? {op_q.addr[23:8], idx_q} : op_q.addr,
				data: (op_q.kind == FEPC_PROGRAM) ? page_mem[idx_q] : op_q.data};
		end
	end

	// outputs
	assign array_op_valid_out = (fifo_cnt_q != 2'h0);
	assign array_op_out = array_op_valid_out ? fifo_mem[rd_ptr_q] : '0;
	assign write_latch_flag_out = latch_q;
	assign op_in_progress_flag_out = !idle;

endmodule // fepc_core
`default_nettype wire

//--- sim/fepc_core_checker.sv
// fepc_core_checker: port-level assertions for the clear and page write sequencer
`timescale 1ns/1ps
`default_nettype none
module fepc_core_checker import fepc_pkg::*; (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic clk_en_in,
	// serial link pins
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic si_in,
	input wire logic [4:0] protect_level_bits_in,
	// flags and array stream
	input wire logic write_latch_flag_out,
	input wire logic op_in_progress_flag_out,
	input wire fepc_op_t array_op_out,
	input wire logic array_op_valid_out,
	input wire logic array_op_ready_in
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);
	// a cycle starts only once select is back high
	sequence s_busy_start;
		$rose(op_in_progress_flag_out);
	endsequence
	AST_START_NEEDS_LATCH: assert property (s_busy_start |-> write_latch_flag_out && cs_n_in)
		else $error("busy rose without latch or with select low");
	AST_BUSY_HELD: assert property (s_busy_start |-> op_in_progress_flag_out [*8])
		else $error("busy dropped early");
	AST_LATCH_ON_END: assert property ($fell(op_in_progress_flag_out) |-> !write_latch_flag_out)
		else $error("latch still set after cycle end");
	AST_LATCH_SET: assert property ($rose(write_latch_flag_out) |-> cs_n_in && !op_in_progress_flag_out)
		else $error("latch set inside frame or while busy");
	AST_WORD_IN_CYCLE: assert property (array_op_valid_out |-> op_in_progress_flag_out)
		else $error("array word outside a cycle");
	// a stalled word must not change or vanish
	AST_WORD_HOLD: assert property (array_op_valid_out && !array_op_ready_in && clk_en_in
		|=> array_op_valid_out && $stable(array_op_out))
		else $error("word lost during stall");
	AST_SECTOR_BASE: assert property (array_op_valid_out && array_op_out.kind == FEPC_SECTOR
		|-> array_op_out.addr[11:0] == 12'h000 && array_op_out.data == 8'hff)
		else $error("sector word not at base");
	AST_BLOCK_BASE: assert property (array_op_valid_out && array_op_out.kind == FEPC_BLOCK32
		|-> array_op_out.addr[14:0] == 15'h0000)
		else $error("32K word not at base");
	AST_BLOCK64_BASE: assert property (array_op_valid_out && array_op_out.kind == FEPC_BLOCK64
		|-> array_op_out.addr[15:0] == 16'h0000)
		else $error("64K word not at base");
	AST_ARRAY_UNPROT: assert property (array_op_valid_out && array_op_out.kind == FEPC_ARRAY
		|-> protect_level_bits_in[2:0] == 3'h0)
		else $error("array clear under protection");
endmodule // fepc_core_checker
`default_nettype wire

//--- sim/fepc_host_model.sv
// fepc_host_model: host side of the serial link, mode 0, msb first
`timescale 1ns/1ps
`default_nettype none
module fepc_host_model (
	// core clock paces the pins
	input wire logic clk_in,
	// serial link pins
	output logic cs_n_out,
	output logic sclk_out,
	output logic si_out
);
	// idle: deselected, clock standing low
	initial begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		si_out = 1'b1;
	end
	// four core cycles a half period gives 160 ns
	task automatic half();
		repeat (4) @(posedge clk_in);
	endtask
	// select falls, clock still low
	task automatic open();
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		half();
	endtask
	// n bits of b, msb first, data set while clock low
	task automatic put(input logic [7:0] b, input int n = 8);
		for (int i = 7; i > 7 - n; i--) begin
			si_out <= b[i];
			half();
			sclk_out <= 1'b1;
			half();
			sclk_out <= 1'b0;
		end
	endtask
	// select rises half a period after the last bit ended; released line flips
	task automatic close();
		half();
		cs_n_out <= 1'b1;
		si_out <= ~si_out;
		repeat (8) @(posedge clk_in);
	endtask
endmodule // fepc_host_model
`default_nettype wire

//--- sim/tb_top.sv
// tb_top: command scenarios for the clear and page write sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import fepc_pkg::*;
	localparam int CYC = 20; // shortened self-timed cycles
	logic clk_in, reset_n_in, ready, cs_n, sclk, si, latch, busy, valid, seen_busy;
	logic clk_en; // core enable, dropped once to prove the freeze
	logic [4:0] prot;
	logic [2:0] rdy_cnt;
	fepc_op_t op;
	fepc_op_t got_q[$]; // words taken by the receiver
	int err_total, checks;
	// clear commands with an inner address and the expected base
	logic [7:0] t_op [5] = '{OP_SECTOR_CLEAR, OP_BLOCK32_CLEAR, OP_BLOCK64_CLEAR, OP_ARRAY_CLEAR_A, OP_ARRAY_CLEAR_B};
	logic [23:0] t_a [5] = '{24'h123456, 24'h12ffff, 24'h0abcde, 24'h000000, 24'h000000};
	logic [23:0] t_b [5] = '{24'h123000, 24'h128000, 24'h0a0000, 24'h000000, 24'h000000};
	fepc_kind_t t_k [5] = '{FEPC_SECTOR, FEPC_BLOCK32, FEPC_BLOCK64, FEPC_ARRAY, FEPC_ARRAY};
	initial begin
		clk_in = 1'b0;
		forever #20 clk_in = ~clk_in;
	end
	fepc_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .si_out(si));
	fepc_core #(.SECTOR_CLEAR_CYC(CYC), .BLOCK32_CLEAR_CYC(CYC), .BLOCK64_CLEAR_CYC(CYC),
		.ARRAY_CLEAR_CYC(CYC), .PAGE_WRITE_CYC(CYC)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
		.clk_en_in(clk_en), .cs_n_in(cs_n), .sclk_in(sclk), .si_in(si), .protect_level_bits_in(prot),
		.write_latch_flag_out(latch), .op_in_progress_flag_out(busy), .array_op_out(op),
		.array_op_valid_out(valid), .array_op_ready_in(ready));
	// receiver stalls three cycles in eight so the buffer backs up
	always @(posedge clk_in) begin
		rdy_cnt <= rdy_cnt + 3'h1;
		ready <= (rdy_cnt < 3'h5);
		if (valid && ready && clk_en) got_q.push_back(op); // a frozen core takes nothing
		if (busy) seen_busy <= 1'b1;
	end
	task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// oldest taken word against the expected one
	task automatic cmp_word(input fepc_op_t exp);
		fepc_op_t got;
		got = 'x;
		if (got_q.size() > 0) got = got_q.pop_front();
		cmp(64'(got), 64'(exp));
	endtask
	// opcode then the given number of address bits; frame left open
	task automatic cmd(input logic [7:0] opc, input logic [23:0] a, input int bits);
		seen_busy <= 1'b0;
		host.open();
		host.put(opc);
		for (int i = 0; i < bits; i += 8) host.put(8'(a >> (16 - i)), (bits - i < 8) ? bits - i : 8);
	endtask
	// bounded wait for the cycle to end; x skips the busy check
	task automatic done(input logic exp_busy, input logic exp_latch);
		int k;
		k = 0;
		while (busy === 1'b1 && k < 4000) begin
			@(posedge clk_in);
			k++;
		end
		if (exp_busy !== 1'bx) cmp(64'(seen_busy), 64'(exp_busy));
		cmp(64'(latch), 64'(exp_latch));
	endtask
	task automatic unlock();
		cmd(OP_WRITE_UNLOCK, 24'h000000, 0);
		host.close();
	endtask
	// enable low mid-cycle: busy must outlast its own short timer
	task automatic freeze();
		clk_en <= 1'b0;
		repeat (40) @(posedge clk_in);
		cmp(64'(busy), 64'h1);
		clk_en <= 1'b1;
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// watchdog, well past the roughly 22k cycles the run needs
	initial begin
		#2400000;
		err_total++;
		stop_test();
	end
	initial begin
		{reset_n_in, seen_busy, ready, rdy_cnt, prot, err_total, checks} = '0;
		clk_en = 1'b1;
		repeat (3) @(posedge clk_in);
		reset_n_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		cmd(OP_SECTOR_CLEAR, 24'h123456, 24);
		host.close();
		done(1'b0, 1'b0);
		unlock();
		cmp(64'(latch), 64'h1);
		cmd(OP_SECTOR_CLEAR, 24'h123456, 20);
		host.close();
		done(1'b0, 1'b1);
		for (int i = 0; i < 5; i++) begin
			unlock();
			cmd(t_op[i], t_a[i], (i < 3) ? 24 : 0);
			host.close();
			if (i == 3) freeze();
			done(1'b1, 1'b0);
			cmp_word({t_k[i], t_b[i], 8'hff});
		end
		// top 64K protected
		prot <= 5'h01;
		unlock();
		cmd(OP_BLOCK64_CLEAR, 24'h1f1234, 24);
		host.close();
		done(1'b0, 1'b1);
		cmd(OP_ARRAY_CLEAR_B, 24'h000000, 0);
		host.close();
		done(1'b0, 1'b1);
		cmd(OP_PAGE_WRITE, 24'h1fff00, 24);
		host.put(8'h55);
		host.close();
		done(1'b0, 1'b1);
		cmd(OP_SECTOR_CLEAR, 24'h1ff000, 24);
		host.close();
		done(1'b0, 1'b1);
		cmd(OP_BLOCK32_CLEAR, 24'h1f8000, 24);
		host.close();
		done(1'bx, 1'b0);
		cmp(64'(got_q.size()), 64'h0);
		prot <= 5'h00;
		// page write cut mid-byte is dropped
		unlock();
		cmd(OP_PAGE_WRITE, 24'h0012fe, 24);
		for (int i = 0; i < 3; i++) host.put(8'ha1 + 8'(i) * 8'h11);
		host.put(8'hd4, 4);
		host.close();
		done(1'b0, 1'b1);
		// three bytes from offset fe wrap to the page start
		cmd(OP_PAGE_WRITE, 24'h0012fe, 24);
		for (int i = 0; i < 3; i++) host.put(8'ha1 + 8'(i) * 8'h11);
		host.close();
		done(1'b1, 1'b0);
		cmp_word({FEPC_PROGRAM, 24'h001200, 8'hc3});
		cmp_word({FEPC_PROGRAM, 24'h0012fe, 8'ha1});
		cmp_word({FEPC_PROGRAM, 24'h0012ff, 8'hb2});
		cmp(64'(got_q.size()), 64'h0);
		// 258 bytes on a fresh page: the first two are overwritten
		unlock();
		cmd(OP_PAGE_WRITE, 24'h004500, 24);
		for (int i = 0; i < 258; i++) host.put(8'(i) ^ ((i > 255) ? 8'h80 : 8'h00));
		host.close();
		done(1'b1, 1'b0);
		for (int i = 0; i < 256; i++) cmp_word({FEPC_PROGRAM, 16'h0045, 8'(i), 8'(i) ^ ((i < 2) ? 8'h80 : 8'h00)});
		stop_test();
	end
endmodule // tb_top
bind fepc_core fepc_core_checker u_chk (.clk_in(clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
	.cs_n_in(cs_n_in), .sclk_in(sclk_in), .si_in(si_in), .protect_level_bits_in(protect_level_bits_in),
	.write_latch_flag_out(write_latch_flag_out), .op_in_progress_flag_out(op_in_progress_flag_out),
	.array_op_out(array_op_out), .array_op_valid_out(array_op_valid_out), .array_op_ready_in(array_op_ready_in));
`default_nettype wire
